// File: inc/ldcr_pkg.sv
// ldcr_pkg: constants and types for the per-channel line diagnostic control registers.
// assumes an APB slave with 32-bit data; register indices are scaled by four to byte addresses.
package ldcr_pkg;

	localparam int unsigned NUM_CH       = 4;
	localparam int unsigned ADDR_W       = 12;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_RX_SLICER_GAIN = 8'h09;
	localparam logic [7:0] IDX_DIAG_PATTERN   = 8'h0a;
	localparam logic [7:0] IDX_LOOPBACK       = 8'h0b;
	localparam logic [7:0] IDX_CH_STRIDE      = 8'h40;

	// reset values
	localparam logic [7:0] RST_RX_SLICER_GAIN = 8'h18;
	localparam logic [7:0] RST_DIAG_PATTERN   = 8'h00;
	localparam logic [7:0] RST_LOOPBACK       = 8'h00;

	// receive_slicer_gain_cfg fields
	localparam int unsigned SLICE_LSB     = 4;
	localparam int unsigned GAIN_LSB      = 0;
	// writable bit mask; reserved bits keep their reset value
	localparam logic [7:0] MASK_RX_SLICER_GAIN = 8'h33;

	// diag_pattern_alarm_ctrl fields
	localparam int unsigned PATT_LSB      = 5;
	localparam int unsigned PATTERN_CLOCK_SOURCE_BIT  = 4;
	localparam int unsigned PRBS_INVERT_BIT  = 3;
	localparam int unsigned ALARM_CRIT_BIT = 2;
	localparam int unsigned AIS_SUB_BIT   = 1;
	localparam int unsigned AUTO_ONES_BIT = 0;
	localparam logic [7:0] MASK_DIAG_PATTERN = 8'h7f;

	// loopback_ctrl fields
	localparam int unsigned AUTO_REMOTE_BIT = 3;
	localparam int unsigned REMOTE_BIT      = 2;
	localparam int unsigned ANALOG_BIT      = 1;
	localparam int unsigned DIGITAL_BIT     = 0;
	localparam logic [7:0] MASK_LOOPBACK = 8'h0f;

	// pattern select codes
	localparam logic [1:0] PATT_NORMAL   = 2'h0;
	localparam logic [1:0] PATT_ONES     = 2'h1;
	localparam logic [1:0] PATT_PSEUDO   = 2'h2;
	localparam logic [1:0] PATT_INBAND   = 2'h3;

	// effective transmit source
	typedef enum logic [2:0] {
		TX_NORMAL,
		TX_ALL_ZEROS,
		TX_ALL_ONES,
		TX_PRBS15,
		TX_QRSS20,
		TX_INBAND
	} ldcr_tx_src_t;

	// decoded per-channel configuration
	typedef struct packed {
		logic [6:0]   slicer_pct;
		logic [5:0]   gain_db;
		ldcr_tx_src_t tx_src;
		logic         pattern_clock_mclk;
		logic         prbs_invert;
		logic         alarm_criterion;
		logic         rx_ais_force;
		logic         tx_all_ones_force;
		logic         auto_remote_loop_en;
		logic         remote_loop_en;
		logic         analog_loop_en;
		logic         digital_loop_en;
	} ldcr_ch_cfg_t;

endpackage

// File: hdl/ldcr_regs.sv
// ldcr_regs: four channels of receive slicer/gain, diagnostic pattern/alarm and loopback
// control registers behind an APB slave, with decoded per-channel control outputs.
// assumes los and pseudo-random bits come from logic on pclk; no synchronisers needed.
//
// Overview of operation
// - slicer threshold bits 5-4, reset 01, give 40/50/60/70 percent mark level.
// - monitor gain bits 1-0, reset 00, give 0/22/26/32 dB receive boost.
// - pattern select bits 6-5 code 00 is normal data, or all zeros with master clock.
// - code 01 sends all ones; code 10 sends a 2^15-1 PRBS in E1 or 2^20-1 QRSS otherwise.
// - code 11 sends the repeated programmable inband loopback code.
// - pattern clock source bit 4, reset 0, picks transmit clock (0) or master clock (1).
// - PRBS invert bit 3 inverts pseudo-random data before sending and before detecting.
// - alarm criterion bit 2 selects which LOS/AIS detection standard is used.
// - AIS substitution bit 1 forces all ones on receive data and clock during LOS.
// - auto all-ones bit 0 sends all ones during LOS, only while pattern select is 01.
// - loopback bit 3 enables automatic remote loopback, reset 0.
// - loopback bit 2 enables remote loopback.
// - loopback bit 1 enables analog loopback.
// - loopback bit 0 enables digital loopback.
// - each channel has its own register copy, spaced 0x40 indices apart, all read/write.
//
// Implementation choice: the APB slave port.
module ldcr_regs
(
	// clock and reset
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	// apb slave
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [ldcr_pkg::ADDR_W-1:0]         paddr,
	input  wire logic [31:0]                         pwdata,
	input  wire logic [3:0]                          pstrb,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// line status from receive logic
	input  wire logic                                e1_mode,
	input  wire logic [ldcr_pkg::NUM_CH-1:0]         los,
	// pseudo-random streams from generator and receive path
	input  wire logic [ldcr_pkg::NUM_CH-1:0]         prbs_gen_bit,
	input  wire logic [ldcr_pkg::NUM_CH-1:0]         prbs_rx_bit,
	// decoded controls
	output logic      [ldcr_pkg::NUM_CH-1:0]         prbs_tx_bit,
	output logic      [ldcr_pkg::NUM_CH-1:0]         prbs_cmp_bit,
	output ldcr_pkg::ldcr_ch_cfg_t [ldcr_pkg::NUM_CH-1:0] ch_cfg
);

	logic [7:0] slicer_gain_q [ldcr_pkg::NUM_CH];
	logic [7:0] diag_q        [ldcr_pkg::NUM_CH];
	logic [7:0] loop_q        [ldcr_pkg::NUM_CH];

	// address decode
	logic [ldcr_pkg::ADDR_W-3:0] word_idx;
	logic [1:0]                  ch_sel;
	logic [5:0]                  reg_off;
	logic                        hit;
	logic [7:0]                  rd_byte;
	logic                        wr_en;
	logic [1:0]                  rsvd_idx;
	logic                        rsvd_bad;
	logic                        access_q;
	logic [31:0]                 prdata_q;
	logic                        err_q;

	assign word_idx = paddr[ldcr_pkg::ADDR_W-1:2];
	// index = base + ch * 0x40, so bits 7:6 are the channel and bits 5:0 the register
	assign ch_sel   = word_idx[7:6];
	assign reg_off  = word_idx[5:0];
	assign rsvd_idx = word_idx[9:8];
	assign rsvd_bad = (rsvd_idx != 2'h0) || (paddr[1:0] != 2'h0);

	always_comb
	begin
		hit     = 1'b0;
		rd_byte = 8'h00;
		case (reg_off)
			ldcr_pkg::IDX_RX_SLICER_GAIN[5:0]:
			begin
				hit     = !rsvd_bad;
				rd_byte = slicer_gain_q[ch_sel];
			end
			ldcr_pkg::IDX_DIAG_PATTERN[5:0]:
			begin
				hit     = !rsvd_bad;
				rd_byte = diag_q[ch_sel];
			end
			ldcr_pkg::IDX_LOOPBACK[5:0]:
			begin
				hit     = !rsvd_bad;
				rd_byte = loop_q[ch_sel];
			end
			default:
			begin
				hit     = 1'b0;
				rd_byte = 8'h00;
			end
		endcase
	end

	// no wait state: setup samples the read, the first access cycle answers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			access_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end
		else
		begin
			access_q <= psel && !penable;
			if (psel && !penable)
			begin
				prdata_q <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
				err_q    <= !hit;
			end
		end
	end

	assign pready  = psel && penable && access_q;
	assign pslverr = pready && err_q;
	assign prdata  = prdata_q;
	// only byte lane 0 carries register data; other lanes are ignored
	assign wr_en   = pready && pwrite && !err_q && pstrb[0];

	genvar c;
	generate
		for (c = 0; c < ldcr_pkg::NUM_CH; c++)
		begin : g_ch
			logic sel;
			logic [1:0] slice;
			logic [1:0] gain;
			logic [1:0] patt;
			logic [7:0] d;
			logic [7:0] l;
			logic [6:0]             slicer_pct_q;
			logic [5:0]             gain_db_q;
			ldcr_pkg::ldcr_tx_src_t tx_src_q;
			logic                   pattern_clock_q;
			logic                   prbs_invert_q;
			logic                   alarm_criterion_q;
			logic                   rx_ais_force_q;
			logic                   tx_all_ones_force_q;
			logic [3:0]             loop_en_q;

			assign sel = wr_en && (ch_sel == 2'(c));

			// reserved bits hold their reset value whatever is written
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					slicer_gain_q[c] <= ldcr_pkg::RST_RX_SLICER_GAIN;
				else if (sel && reg_off == ldcr_pkg::IDX_RX_SLICER_GAIN[5:0])
					slicer_gain_q[c] <= (pwdata[7:0] & ldcr_pkg::MASK_RX_SLICER_GAIN)
						| (ldcr_pkg::RST_RX_SLICER_GAIN & ~ldcr_pkg::MASK_RX_SLICER_GAIN);
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					diag_q[c] <= ldcr_pkg::RST_DIAG_PATTERN;
				else if (sel && reg_off == ldcr_pkg::IDX_DIAG_PATTERN[5:0])
					diag_q[c] <= pwdata[7:0] & ldcr_pkg::MASK_DIAG_PATTERN;
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					loop_q[c] <= ldcr_pkg::RST_LOOPBACK;
				else if (sel && reg_off == ldcr_pkg::IDX_LOOPBACK[5:0])
					loop_q[c] <= pwdata[7:0] & ldcr_pkg::MASK_LOOPBACK;
			end

			assign slice = slicer_gain_q[c][ldcr_pkg::SLICE_LSB +: 2];
			assign gain  = slicer_gain_q[c][ldcr_pkg::GAIN_LSB +: 2];
			assign d     = diag_q[c];
			assign l     = loop_q[c];
			assign patt  = d[ldcr_pkg::PATT_LSB +: 2];

			// decoded controls: one process per concern, all one cycle behind the register
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					slicer_pct_q <= '0;
				end
				else
				begin
					case (slice)
						2'h0:    slicer_pct_q <= 7'h28;
						2'h1:    slicer_pct_q <= 7'h32;
						2'h2:    slicer_pct_q <= 7'h3c;
						default: slicer_pct_q <= 7'h46;
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					gain_db_q <= '0;
				end
				else
				begin
					case (gain)
						2'h0:    gain_db_q <= 6'h00;
						2'h1:    gain_db_q <= 6'h16;
						2'h2:    gain_db_q <= 6'h1a;
						default: gain_db_q <= 6'h20;
					endcase
				end
			end

			// line mode is read live, so a mode change retargets an active pattern
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					tx_src_q <= ldcr_pkg::TX_NORMAL;
				end
				else
				begin
					case (patt)
						ldcr_pkg::PATT_NORMAL:
							tx_src_q <= d[ldcr_pkg::PATTERN_CLOCK_SOURCE_BIT]
								? ldcr_pkg::TX_ALL_ZEROS : ldcr_pkg::TX_NORMAL;
						ldcr_pkg::PATT_ONES:
							tx_src_q <= ldcr_pkg::TX_ALL_ONES;
						ldcr_pkg::PATT_PSEUDO:
							tx_src_q <= e1_mode
								? ldcr_pkg::TX_PRBS15 : ldcr_pkg::TX_QRSS20;
						default:
							tx_src_q <= ldcr_pkg::TX_INBAND;
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pattern_clock_q   <= 1'b0;
					prbs_invert_q     <= 1'b0;
					alarm_criterion_q <= 1'b0;
				end
				else
				begin
					pattern_clock_q   <= d[ldcr_pkg::PATTERN_CLOCK_SOURCE_BIT];
					prbs_invert_q     <= d[ldcr_pkg::PRBS_INVERT_BIT];
					alarm_criterion_q <= d[ldcr_pkg::ALARM_CRIT_BIT];
				end
			end

			// both forces follow los live; they clear a cycle after los drops
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					rx_ais_force_q      <= 1'b0;
					tx_all_ones_force_q <= 1'b0;
				end
				else
				begin
					rx_ais_force_q      <= d[ldcr_pkg::AIS_SUB_BIT] && los[c];
					// gated by pattern select so a stray bit cannot fire
					tx_all_ones_force_q <= d[ldcr_pkg::AUTO_ONES_BIT] && los[c]
						&& (patt == ldcr_pkg::PATT_ONES);
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					loop_en_q <= 4'h0;
				end
				else
				begin
					loop_en_q[3] <= l[ldcr_pkg::AUTO_REMOTE_BIT];
					loop_en_q[2] <= l[ldcr_pkg::REMOTE_BIT];
					loop_en_q[1] <= l[ldcr_pkg::ANALOG_BIT];
					loop_en_q[0] <= l[ldcr_pkg::DIGITAL_BIT];
				end
			end

			// same invert on both paths keeps generator and detector in step
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					prbs_tx_bit[c]  <= 1'b0;
					prbs_cmp_bit[c] <= 1'b0;
				end
				else
				begin
					prbs_tx_bit[c]  <= prbs_gen_bit[c] ^ d[ldcr_pkg::PRBS_INVERT_BIT];
					prbs_cmp_bit[c] <= prbs_rx_bit[c] ^ d[ldcr_pkg::PRBS_INVERT_BIT];
				end
			end

			assign ch_cfg[c].slicer_pct          = slicer_pct_q;
			assign ch_cfg[c].gain_db             = gain_db_q;
			assign ch_cfg[c].tx_src              = tx_src_q;
			assign ch_cfg[c].pattern_clock_mclk  = pattern_clock_q;
			assign ch_cfg[c].prbs_invert         = prbs_invert_q;
			assign ch_cfg[c].alarm_criterion     = alarm_criterion_q;
			assign ch_cfg[c].rx_ais_force        = rx_ais_force_q;
			assign ch_cfg[c].tx_all_ones_force   = tx_all_ones_force_q;
			assign ch_cfg[c].auto_remote_loop_en = loop_en_q[3];
			assign ch_cfg[c].remote_loop_en      = loop_en_q[2];
			assign ch_cfg[c].analog_loop_en      = loop_en_q[1];
			assign ch_cfg[c].digital_loop_en     = loop_en_q[0];
		end
	endgenerate

endmodule

// File: bench/ldcr_regs_assertions.sv
// ldcr_regs_assertions: port-level checks of the line diagnostic control registers.
// assumes bind to ldcr_regs, one pclk domain, asynchronous active-low presetn.
module ldcr_regs_assertions
(
	// clock and reset
	input logic                         pclk,
	input logic                         presetn,
	// apb
	input logic                         psel,
	input logic                         penable,
	input logic                         pwrite,
	input logic [11:0]                  paddr,
	input logic                         pready,
	input logic                         pslverr,
	// line side and decode
	input logic [3:0]                   los,
	input logic [3:0]                   prbs_gen_bit,
	input logic [3:0]                   prbs_tx_bit,
	input ldcr_pkg::ldcr_ch_cfg_t [3:0] ch_cfg
);
	logic [3:0] inv;

	always_comb
		for (int i = 0; i < 4; i++)
			inv[i] = ch_cfg[i].prbs_invert;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ready; pready |-> psel && penable && $past(psel && !penable); endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_misal; (pready && paddr[1:0] != 2'h0) |-> pslverr; endproperty
	// invert only judged while the setting holds; a fresh write needs a cycle to land
	property p_inv; ($stable(inv) && $past(presetn)) |-> prbs_tx_bit == ($past(prbs_gen_bit) ^ inv);
	endproperty
	property p_ais; ch_cfg[3].rx_ais_force |-> $past(los[3]); endproperty
	property p_ones; ch_cfg[3].tx_all_ones_force |->
		$past(los[3]) && ch_cfg[3].tx_src == ldcr_pkg::TX_ALL_ONES; endproperty
	property p_slice; $past(presetn) |-> ch_cfg[1].slicer_pct inside {7'h28, 7'h32, 7'h3c, 7'h46};
	endproperty
	// register lands at the access edge, decode one edge later
	property p_wr; $changed(ch_cfg[1].gain_db) |-> $past(pready && pwrite, 2); endproperty

	a_ready: assert property (p_ready) else $error("pready outside access");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_misal: assert property (p_misal) else $error("misaligned access accepted");
	a_inv: assert property (p_inv) else $error("transmit pseudo-random bit wrong");
	a_ais: assert property (p_ais) else $error("receive substitution without los");
	a_ones: assert property (p_ones) else $error("all-ones forced wrongly");
	a_slice: assert property (p_slice) else $error("slicer level outside table");
	a_wr: assert property (p_wr) else $error("gain changed without write");

	c_err: cover property (pslverr);
	c_ones: cover property (ch_cfg[3].tx_all_ones_force);
	c_ais: cover property (ch_cfg[3].rx_ais_force);
endmodule

bind ldcr_regs ldcr_regs_assertions u_chk
(
	.pclk         (pclk),
	.presetn      (presetn),
	.psel         (psel),
	.penable      (penable),
	.pwrite       (pwrite),
	.paddr        (paddr),
	.pready       (pready),
	.pslverr      (pslverr),
	.los          (los),
	.prbs_gen_bit (prbs_gen_bit),
	.prbs_tx_bit  (prbs_tx_bit),
	.ch_cfg       (ch_cfg)
);

// File: bench/ldcr_regs_tb.sv
// ldcr_regs_tb: directed register, decode and refusal checks for ldcr_regs.
// assumes the checker is bound beside the design; pstrb all-ones but for one lane check.
module ldcr_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
`define CHK(g, x) begin num_checks++; if ((g) !== (x)) begin bad_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, x); end end

	logic                         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]                  paddr = 0;
	logic [31:0]                  pwdata = 0, prdata, r;
	logic                         pready, pslverr, e, e1_mode = 0;
	logic [3:0]                   los = 0, prbs_gen_bit = 0, prbs_rx_bit = 0, pstrb = 4'hf;
	logic [3:0]                   prbs_tx_bit, prbs_cmp_bit;
	ldcr_pkg::ldcr_ch_cfg_t [3:0] ch_cfg;
	int                           bad_count = 0, num_checks = 0, cyc = 0;

	ldcr_regs DUT
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.pstrb        (pstrb),
		.prdata       (prdata),
		.pready       (pready),
		.pslverr      (pslverr),
		.e1_mode      (e1_mode),
		.los          (los),
		.prbs_gen_bit (prbs_gen_bit),
		.prbs_rx_bit  (prbs_rx_bit),
		.prbs_tx_bit  (prbs_tx_bit),
		.prbs_cmp_bit (prbs_cmp_bit),
		.ch_cfg       (ch_cfg)
	);

	always #4 pclk = ~pclk;

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count++;
			finish_test();
		end
	end

	function automatic logic [11:0] ad(input logic [1:0] c, input logic [7:0] i);
		return {2'h0, c, i[5:0], 2'h0};
	endfunction

	// master waits on pready itself: no latency is assumed
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic nxt;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task automatic t_reset;
		for (int c = 0; c < 16; c++)
		begin
			apb(0, ad(c[3:2], 8'h09 + c[1:0]), 8'h00);
			`CHK(r, (c[1:0] == 0) ? 32'h18 : 32'h0)
			`CHK(ch_cfg[c[3:2]].slicer_pct, 7'h32)
		end
	endtask

	task automatic t_slice;
		logic [6:0] pct[4] = '{7'h28, 7'h32, 7'h3c, 7'h46};
		logic [5:0] gdb[4] = '{6'h00, 6'h16, 6'h1a, 6'h20};
		for (int v = 0; v < 4; v++)
		begin
			apb(1, ad(1, ldcr_pkg::IDX_RX_SLICER_GAIN), {2'h0, v[1:0], 2'h2, v[1:0]});
			apb(0, ad(1, ldcr_pkg::IDX_RX_SLICER_GAIN), 8'h00);
			`CHK(r, {24'h0, 2'h0, v[1:0], 2'h2, v[1:0]})
			`CHK(ch_cfg[1].slicer_pct, pct[v])
			`CHK(ch_cfg[1].gain_db, gdb[v])
		end
		apb(0, ad(0, ldcr_pkg::IDX_RX_SLICER_GAIN), 8'h00);
		`CHK(r, 32'h18)
	endtask

	task automatic t_patt;
		ldcr_pkg::ldcr_tx_src_t x;
		for (int k = 0; k < 16; k++)
		begin
			@(posedge pclk);
			e1_mode <= k[3];
			apb(1, ad(2, ldcr_pkg::IDX_DIAG_PATTERN), {1'b0, k[2:0], 4'h0});
			nxt();
			x = (k[2:1] == 0) ? (k[0] ? ldcr_pkg::TX_ALL_ZEROS : ldcr_pkg::TX_NORMAL) :
				(k[2:1] == 1) ? ldcr_pkg::TX_ALL_ONES : (k[2:1] == 3) ? ldcr_pkg::TX_INBAND :
				(k[3] ? ldcr_pkg::TX_PRBS15 : ldcr_pkg::TX_QRSS20);
			`CHK(ch_cfg[2].tx_src, x)
			`CHK(ch_cfg[2].pattern_clock_mclk, k[0])
		end
	endtask

	task automatic t_alarm;
		@(posedge pclk);
		los <= 4'h8;
		prbs_gen_bit <= 4'hf;
		prbs_rx_bit <= 4'h5;
		apb(1, ad(3, ldcr_pkg::IDX_DIAG_PATTERN), 8'h2f);
		nxt();
		`CHK(ch_cfg[3].rx_ais_force, 1'b1)
		`CHK(ch_cfg[3].tx_all_ones_force, 1'b1)
		`CHK(ch_cfg[3].alarm_criterion, 1'b1)
		`CHK(ch_cfg[3].prbs_invert, 1'b1)
		`CHK({prbs_tx_bit, prbs_cmp_bit}, 8'h7d)
		// all-ones must drop once the pattern leaves code 01
		apb(1, ad(3, ldcr_pkg::IDX_DIAG_PATTERN), 8'h4b);
		nxt();
		`CHK(ch_cfg[3].tx_all_ones_force, 1'b0)
		`CHK(ch_cfg[3].alarm_criterion, 1'b0)
		@(posedge pclk);
		los <= 4'h0;
		nxt();
		`CHK(ch_cfg[3].rx_ais_force, 1'b0)
	endtask

	task automatic t_loop;
		for (int b = 0; b < 4; b++)
		begin
			apb(1, ad(0, ldcr_pkg::IDX_LOOPBACK), 8'h1 << b);
			apb(0, ad(0, ldcr_pkg::IDX_LOOPBACK), 8'h00);
			`CHK(r, 32'h1 << b)
			`CHK({ch_cfg[0].auto_remote_loop_en, ch_cfg[0].remote_loop_en,
				ch_cfg[0].analog_loop_en, ch_cfg[0].digital_loop_en}, 4'h1 << b)
		end
	endtask

	task automatic t_err;
		logic [11:0] bad[3] = '{12'h026, 12'h0fc, 12'h424};
		for (int i = 0; i < 3; i++)
		begin
			apb(i[0], bad[i], 8'hff);
			`CHK({e, r}, 33'h100000000)
		end
		// lane 0 disabled: write dropped silently, loopback keeps its last value
		@(posedge pclk);
		pstrb <= 4'h0;
		apb(1, ad(0, ldcr_pkg::IDX_LOOPBACK), 8'h01);
		`CHK({e, r}, 33'h000000000)
		pstrb <= 4'hf;
		apb(0, ad(0, ldcr_pkg::IDX_LOOPBACK), 8'h00);
		`CHK(r, 32'h8)
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_slice();
		t_patt();
		t_alarm();
		t_loop();
		t_err();
		finish_test();
	end
endmodule
